// file: pkg/pph_pkg.sv
package pph_pkg;
    // Clock rate of the block.
    localparam int CLK_MHZ = 25;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    // Settling time for filtered cable inputs, least time, rounds up.
    localparam int SETTLE_NS = 50;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    // Data setup before the strobe falls, least time, rounds up.
    localparam int SETUP_NS = 600;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    // Strobe low pulse width in the FIFO mode, least time.
    localparam int PULSE_NS = 600;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    // Busy inactive to the next strobe in the FIFO mode, least time.
    localparam int GAP_NS = 680;
    localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 6;

    // Port operating modes.
    typedef enum logic [1:0] {
        PPH_MODE_COMPAT = 2'h0,
        PPH_MODE_FIFO = 2'h1,
        PPH_MODE_ECP = 2'h2,
        PPH_MODE_EPP = 2'h3
    } pph_mode_t;

    // Control lines driven toward the cable; strobe_n and write_n are active low names.
    typedef struct packed {
        logic strobe_n;
        logic auto_linefeed_line;
        logic write_n;
    } pph_ctl_t;

    // Status lines sampled from the cable.
    typedef struct packed {
        logic busy;
        logic ack_n;
        logic fault_n;
        logic wait_n;
    } pph_sts_t;
endpackage

// file: rtl/pph_port.sv
`timescale 1ns/10ps
// Functional notes
// - FIFO mode ignores acknowledge and paces each byte on Busy only.
// - FIFO mode streams DMA bytes at near peak forward byte rate.
// - ECP forward idle: strobe held high, peripheral keeps Busy low.
// - Forward byte: Busy low, strobe low, Busy high, strobe high, Busy low.
// - Data is stable for the setup interval before strobe falls.
// - ECP reverse idle: nACK high, host acknowledge line held low.
// - Reverse byte: ack low, nACK low, ack high, nACK high, ack low.
// - Drivers open-drain in compatible mode, push-pull in ECP mode.
// - Driver type switches without glitching any output line.
// - nWAIT counts as settled only after 50 ns without transition.
// - nWRITE stays inactive high whenever no EPP write is running.
module pph_port
    import pph_pkg::*;
(
    input wire logic clk, // System clock, 25 MHz.
    input wire logic srst, // Synchronous reset, active high.
    input wire pph_mode_t mode, // Operating mode.
    input wire logic reverse_req, // Ask for reverse direction in ECP.
    input wire logic [7:0] tx_data, // Byte to send.
    input wire logic tx_valid, // Byte offered.
    output logic tx_ready, // Byte taken this cycle.
    input wire logic epp_wr_start, // Start an EPP write of tx_data.
    output logic [7:0] rx_data, // Last byte received in reverse.
    output logic rx_valid, // One-cycle pulse with rx_data.
    output logic periph_req, // Synchronised, unfiltered peripheral reverse request.
    output logic wait_settled_n, // Filtered nWAIT level.
    output logic busy_o, // Transfer engine not idle.
    input wire logic [7:0] data_i, // Data pins in.
    output logic [7:0] data_o, // Data pins out.
    output logic [7:0] data_oe, // Data pin drive enables.
    output pph_ctl_t ctl_o, // Control pins out.
    output logic [2:0] ctl_oe, // Control pin drive enables.
    input wire pph_sts_t sts_i // Status pins in, asynchronous.
);
    typedef enum logic [2:0] {
        S_IDLE, S_SETUP, S_STB, S_WAIT_HI, S_WAIT_LO, S_REV, S_REV_HI
    } pph_state_t;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n);
    endfunction

    pph_sts_t sync1_reg, sync2_reg;
    logic [7:0] din1_reg, din2_reg;
    logic wait_last_reg, wait_reg;
    logic [CNT_W-1:0] wait_cnt_reg;
    pph_state_t st_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [7:0] dout_reg;
    pph_ctl_t ctl_reg;
    logic pushpull_reg, epp_wr_reg;
    logic [7:0] rx_reg;
    logic rx_v_reg;

    // Two-flop synchronisers; the first stage is read by nothing else.
    always_ff @(posedge clk) begin
        sync1_reg <= sts_i;
        sync2_reg <= sync1_reg;
        din1_reg <= data_i;
        din2_reg <= din1_reg;
    end

    // Deglitch nWAIT so cable ringing cannot end a cycle early.
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_last_reg <= 1'b1;
            wait_reg <= 1'b1;
            wait_cnt_reg <= '0;
        end else if (sync2_reg.wait_n != wait_last_reg) begin
            wait_last_reg <= sync2_reg.wait_n;
            wait_cnt_reg <= '0;
        end else if (wait_cnt_reg < cyc(SETTLE_CYC)) begin
            wait_cnt_reg <= wait_cnt_reg + cyc(1);
        end else begin
            wait_reg <= wait_last_reg;
        end
    end

    // Switch driver type only while idle with lines at their idle
    // levels, so the level driven never changes during the swap.
    always_ff @(posedge clk) begin
        if (srst) begin
            pushpull_reg <= 1'b0;
        end else if (st_reg == S_IDLE) begin
            pushpull_reg <= (mode == PPH_MODE_ECP);
        end
    end

    // Transfer engine for FIFO, ECP forward/reverse and EPP write.
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= S_IDLE;
            cnt_reg <= '0;
            dout_reg <= '0;
            ctl_reg <= '{strobe_n: 1'b1, auto_linefeed_line: 1'b1,
                         write_n: 1'b1};
            epp_wr_reg <= 1'b0;
            rx_reg <= '0;
            rx_v_reg <= 1'b0;
        end else begin
            rx_v_reg <= 1'b0;
            if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - cyc(1);
            end
            unique case (st_reg)
                S_IDLE: begin
                    ctl_reg.strobe_n <= 1'b1;
                    ctl_reg.write_n <= 1'b1;
                    ctl_reg.auto_linefeed_line <= 1'b1;
                    epp_wr_reg <= 1'b0;
                    if (mode == PPH_MODE_ECP && reverse_req) begin
                        ctl_reg.auto_linefeed_line <= 1'b0;
                        st_reg <= S_REV;
                    end else if (tx_valid && !sync2_reg.busy
                                 && cnt_reg == '0 && mode != PPH_MODE_EPP) begin
                        dout_reg <= tx_data;
                        cnt_reg <= cyc(SETUP_CYC);
                        st_reg <= S_SETUP;
                    end else if (mode == PPH_MODE_EPP && epp_wr_start
                                 && tx_valid && !wait_reg) begin
                        dout_reg <= tx_data;
                        ctl_reg.write_n <= 1'b0;
                        epp_wr_reg <= 1'b1;
                        st_reg <= S_WAIT_HI;
                    end
                end
                S_SETUP: begin
                    if (cnt_reg == '0) begin
                        ctl_reg.strobe_n <= 1'b0;
                        cnt_reg <= cyc(PULSE_CYC);
                        st_reg <= (mode == PPH_MODE_FIFO) ? S_STB : S_WAIT_HI;
                    end
                end
                S_STB: begin
                    if (cnt_reg == '0) begin
                        ctl_reg.strobe_n <= 1'b1;
                        st_reg <= S_WAIT_LO;
                    end
                end
                S_WAIT_HI: begin
                    if (epp_wr_reg) begin
                        if (wait_reg) begin
                            ctl_reg.write_n <= 1'b1;
                            st_reg <= S_IDLE;
                        end
                    end else if (sync2_reg.busy) begin
                        ctl_reg.strobe_n <= 1'b1;
                        st_reg <= S_WAIT_LO;
                    end
                end
                S_WAIT_LO: begin
                    if (!sync2_reg.busy) begin
                        cnt_reg <= cyc(GAP_CYC);
                        st_reg <= S_IDLE;
                    end
                end
                S_REV: begin
                    if (!reverse_req) begin
                        ctl_reg.auto_linefeed_line <= 1'b1;
                        st_reg <= S_IDLE;
                    end else if (!sync2_reg.ack_n) begin
                        rx_reg <= din2_reg;
                        ctl_reg.auto_linefeed_line <= 1'b1;
                        st_reg <= S_REV_HI;
                    end
                end
                S_REV_HI: begin
                    if (sync2_reg.ack_n) begin
                        ctl_reg.auto_linefeed_line <= 1'b0;
                        rx_v_reg <= 1'b1;
                        st_reg <= S_REV;
                    end
                end
            endcase
        end
    end

    // Open-drain drives only lows; push-pull drives both levels.
    always_comb begin
        data_o = dout_reg;
        ctl_o = ctl_reg;
        if (pushpull_reg || st_reg == S_REV || st_reg == S_REV_HI) begin
            data_oe = (st_reg == S_REV || st_reg == S_REV_HI) ? 8'h00 : 8'hff;
            ctl_oe = 3'h7;
        end else begin
            data_oe = ~dout_reg;
            ctl_oe = ~ctl_reg;
        end
    end

    // Handshake and status outputs.
    assign tx_ready = (st_reg == S_IDLE) && !srst
        && ((mode != PPH_MODE_EPP && !(mode == PPH_MODE_ECP && reverse_req)
             && !sync2_reg.busy && cnt_reg == '0)
            || (mode == PPH_MODE_EPP && epp_wr_start && !wait_reg));
    assign rx_data = rx_reg;
    assign rx_valid = rx_v_reg;
    assign periph_req = !sync2_reg.fault_n;
    assign wait_settled_n = wait_reg;
    assign busy_o = (st_reg != S_IDLE);
endmodule

// file: test/pph_checker.sv
`timescale 1ns/10ps
// Pin-level checks of the host port handshakes and idle levels.
module pph_checker
    import pph_pkg::*;
(
    input wire logic clk, // Port clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic reverse_req, // Reverse direction request.
    input wire logic tx_ready, // Byte accepted this cycle.
    input wire logic busy_o, // Transfer engine not idle.
    input wire pph_mode_t mode, // Operating mode.
    input wire logic [7:0] data_o, // Data pins out.
    input wire logic [7:0] data_oe, // Data pin drive enables.
    input wire pph_ctl_t ctl_o, // Control pins.
    input wire logic [2:0] ctl_oe, // Control enables.
    input wire pph_sts_t sts_i // Status pins.
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Idle lines, strobe timing and the two interlocks.
    idle_strobe_a: assert property (!busy_o |-> ctl_o.strobe_n)
        else $error("strobe low while idle");
    data_setup_a: assert property ($fell(ctl_o.strobe_n) |->
        $past(data_o, SETUP_CYC) == data_o) else $error("data not set up");
    fifo_pulse_a: assert property (mode == PPH_MODE_FIFO &&
        $fell(ctl_o.strobe_n) |-> ##15 !ctl_o.strobe_n ##1 ctl_o.strobe_n)
        else $error("fifo strobe width wrong");
    ecp_rise_a: assert property (mode == PPH_MODE_ECP &&
        $rose(ctl_o.strobe_n) |-> sts_i.busy) else $error("strobe rose early");
    alf_rise_a: assert property (reverse_req &&
        $rose(ctl_o.auto_linefeed_line) |-> !sts_i.ack_n)
        else $error("host ack rose early");
    open_drain_a: assert property (mode == PPH_MODE_COMPAT &&
        $past(mode) == PPH_MODE_COMPAT && $past(mode, 2) == PPH_MODE_COMPAT
        |-> ctl_oe == ~ctl_o && data_oe == ~data_o) else $error("not open");
    drive_switch_a: assert property ($changed(ctl_oe) && !busy_o |->
        ctl_o.strobe_n && ctl_o.write_n) else $error("switch glitch");
    ready_idle_a: assert property (tx_ready |-> !busy_o &&
        !(mode == PPH_MODE_ECP && reverse_req)) else $error("ready wrong");
endmodule
bind pph_port pph_checker chk (.clk, .srst, .reverse_req, .tx_ready, .busy_o,
    .mode, .data_o, .data_oe, .ctl_o, .ctl_oe, .sts_i);

// file: test/pph_periph_model.sv
`timescale 1ns/10ps
// Cable peripheral: answers strobes after lag cycles, sends one byte back.
module pph_periph_model
    import pph_pkg::*;
(
    input wire logic clk, // Bench clock.
    input wire pph_ctl_t ctl, // Host control lines.
    input wire logic [7:0] lag, // Answer delay in cycles.
    input wire logic rev_go, // Offer a reverse byte.
    input wire logic [7:0] rev_byte, // Byte to offer.
    output pph_sts_t sts, // Status lines.
    output logic [7:0] pd // Data driven by the peripheral.
);
    logic [7:0] cnt;
    logic [1:0] ph;
    initial begin
        sts = 4'h6;
        pd = 8'h00;
        cnt = 8'h00;
        ph = 2'h0;
    end
    // One process keeps the forward, write and reverse handshakes.
    always @(posedge clk) begin
        cnt <= (!ctl.strobe_n || !ctl.write_n) ? cnt + 8'h1 : 8'h0;
        sts.fault_n <= !rev_go;
        if (!ctl.strobe_n && cnt == lag) sts.busy <= 1'b1;
        if (ctl.strobe_n) sts.busy <= 1'b0;
        // The wait line rings once before it settles, as a long cable does.
        sts.wait_n <= !ctl.write_n && (cnt == 8'h3 || cnt > 8'h7);
        case (ph)
            2'h0: if (rev_go && !ctl.auto_linefeed_line) begin
                pd <= rev_byte;
                ph <= 2'h1;
            end
            2'h1: begin
                sts.ack_n <= 1'b0;
                ph <= 2'h2;
            end
            2'h2: if (ctl.auto_linefeed_line) begin
                sts.ack_n <= 1'b1;
                pd <= ~rev_byte;
                ph <= 2'h3;
            end
            default: if (!rev_go) ph <= 2'h0;
        endcase
    end
endmodule

// file: test/test_ecp_epp_parallel_handshake.sv
`timescale 1ns/10ps
// Runs forward, reverse and write transfers against the peripheral model.
module test_ecp_epp_parallel_handshake;
    import pph_pkg::*;
    logic clk, srst, reverse_req, tx_valid, tx_ready, epp_wr_start, rev_go;
    logic rx_valid, periph_req, wait_settled_n, busy_o;
    logic [7:0] tx_data, rx_data, data_i, data_o, data_oe, lag, rev_byte, pd;
    pph_mode_t mode;
    pph_ctl_t ctl_o;
    logic [2:0] ctl_oe;
    pph_sts_t sts_i;
    int miscompares = 0;
    int n_checks = 0;
    int i;
    logic taken;
    pph_port uut (.clk, .srst, .mode, .reverse_req, .tx_data, .tx_valid,
        .tx_ready, .epp_wr_start, .rx_data, .rx_valid, .periph_req,
        .wait_settled_n, .busy_o, .data_i, .data_o, .data_oe, .ctl_o,
        .ctl_oe, .sts_i);
    pph_periph_model peer (.clk, .ctl(ctl_o), .lag, .rev_go, .rev_byte,
        .sts(sts_i), .pd);
    // The data wire shows whichever side drives it.
    assign data_i = (data_oe & data_o) | (~data_oe & pd);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Offers one byte and holds it until an edge samples ready high.
    // Ready is read at the edge itself, so a take is never missed.
    task send(input logic [7:0] b, input logic epp);
        tx_data = b;
        tx_valid = 1'b1;
        epp_wr_start = epp;
        taken = 1'b0;
        for (i = 0; i < 400 && !taken; i++) begin
            @(posedge clk);
            taken = (tx_ready === 1'b1);
        end
        #1;
        tx_valid = 1'b0;
        epp_wr_start = 1'b0;
        chk("byte taken", 8'h1, {7'h0, taken});
    endtask
    task t_fwd(input pph_mode_t m, input logic [7:0] b, input logic [7:0] l);
        mode = m;
        lag = l;
        send(b, 1'b0);
        for (i = 0; i < 400 && ctl_o.strobe_n !== 1'b0; i++) step(1);
        chk("data at strobe", b, data_o);
        chk("ctl oe", m == PPH_MODE_ECP ? 8'h7 : 8'h4, {5'h0, ctl_oe});
        chk("data oe", m == PPH_MODE_ECP ? 8'hff : ~b, data_oe);
        for (i = 0; i < 400 && busy_o !== 1'b0; i++) step(1);
        chk("strobe idle", 8'h1, {7'h0, ctl_o.strobe_n});
    endtask
    task t_rev(input logic [7:0] b);
        mode = PPH_MODE_ECP;
        reverse_req = 1'b1;
        rev_byte = b;
        rev_go = 1'b1;
        step(4);
        chk("peripheral request", 8'h1, {7'h0, periph_req});
        for (i = 0; i < 400 && rx_valid !== 1'b1; i++) step(1);
        chk("reverse byte", b, rx_data);
        rev_go = 1'b0;
        step(6);
        chk("host ack idle", 8'h0, {7'h0, ctl_o.auto_linefeed_line});
        chk("data released", 8'h0, data_oe);
        reverse_req = 1'b0;
        step(6);
    endtask
    task t_epp;
        mode = PPH_MODE_EPP;
        send(8'h3c, 1'b1);
        for (i = 0; i < 400 && ctl_o.write_n !== 1'b0; i++) step(1);
        step(8);
        chk("write through ringing", 8'h0, {7'h0, ctl_o.write_n});
        for (i = 0; i < 400 && ctl_o.write_n !== 1'b1; i++) step(1);
        chk("settled wait", 8'h1, {7'h0, wait_settled_n});
        step(3);
        chk("write idle", 8'h1, {7'h0, ctl_o.write_n});
    endtask
    // Reset first, then back-to-back bytes, slow answers, reverse and write.
    initial begin
        srst = 1'b1;
        {reverse_req, tx_valid, epp_wr_start, rev_go} = 4'h0;
        {tx_data, lag, rev_byte} = 24'h0;
        mode = PPH_MODE_COMPAT;
        step(4);
        chk("reset control", 8'h7, {5'h0, ctl_o});
        chk("reset data drive", 8'hff, data_oe);
        srst = 1'b0;
        step(3);
        t_fwd(PPH_MODE_FIFO, 8'ha5, 8'h0);
        t_fwd(PPH_MODE_FIFO, 8'h5a, 8'h0);
        t_fwd(PPH_MODE_ECP, 8'hc3, 8'h14);
        t_rev(8'h96);
        t_fwd(PPH_MODE_ECP, 8'h01, 8'h2);
        t_epp();
        t_fwd(PPH_MODE_COMPAT, 8'h69, 8'h3);
        print_verdict();
    end
    // Cuts a hang short well beyond the expected run length.
    initial begin
        #400000;
        miscompares++;
        print_verdict();
    end
endmodule
